//--- rtl/rhc_pkg.sv
/*
 * shared constants for the hours / interval / calibration block: register
 * offsets, field positions, reset values and derived cycle counts.
 * assumes a single 250 MHz system clock; all slower rates are enables.
 */
package rhc_pkg;

    // system clock and crystal reference
    localparam longint CLK_HZ        = 250_000_000;
    localparam longint XTAL_HZ       = 32_768;
    localparam int     PHASE_W       = 32;
    // phase step that makes one tick per crystal period (truncated)
    localparam longint PHASE_INC_NOM = (XTAL_HZ << PHASE_W) / CLK_HZ;

    // crystal trim: 2 ppm per lsb, sum limited to +/-248 ppm
    localparam int     TRIM_LSB_PPM  = 2;
    localparam int     TRIM_MAX_PPM  = 248;
    localparam int     TRIM_LIM      = TRIM_MAX_PPM / TRIM_LSB_PPM;
    localparam longint TRIM_STEP     = (PHASE_INC_NOM * TRIM_LSB_PPM + 999_999) / 1_000_000;

    // short-window calibration speeds timekeeping up by this factor
    localparam int     FAST_MULT     = 125;

    // configuration is resampled once per 128 Hz period
    localparam int     CFG_HZ        = 128;
    localparam int     CFG_DIV       = int'(XTAL_HZ) / CFG_HZ;

    // calibration output half periods, counted in timekeeping ticks
    localparam int     CAL_HALF_00   = int'(XTAL_HZ) / (2 * 1);
    localparam int     CAL_HALF_01   = int'(XTAL_HZ) / (2 * 512);
    localparam int     CAL_HALF_10   = int'(XTAL_HZ) * FAST_MULT / (2 * 500);
    localparam int     CAL_HALF_11   = int'(XTAL_HZ) * FAST_MULT / (2 * 16_384);

    // register offsets
    localparam logic [7:0] OFS_HOURS_COUNT  = 8'ha5;
    localparam logic [7:0] OFS_IVL_COMPARE  = 8'ha6;
    localparam logic [7:0] OFS_NOM_TRIM     = 8'hf6;
    localparam logic [7:0] OFS_THERM_TRIM   = 8'hf7;
    localparam logic [7:0] OFS_PIN_FUNC     = 8'hff;
    localparam logic [7:0] REG_RESET        = 8'h00;

    // hour wrap points
    localparam logic [7:0] HOUR_LAST_24     = 8'h17;
    localparam logic [7:0] HOUR_LAST_256    = 8'hff;

    // pin function fields
    localparam int PF_CAL_EN    = 7;
    localparam int PF_RATE_HI   = 6;
    localparam int PF_RATE_LO   = 5;
    localparam int PF_IRQ1_HI   = 3;
    localparam int PF_IRQ1_LO   = 1;
    localparam int PF_IRQ0      = 0;

endpackage

//--- rtl/rhc_xtal_tick.sv
/*
 * calibrated timekeeping tick: a phase accumulator at the system clock
 * makes one enable per crystal period, nudged by the summed trim values.
 * assumes trims and fast mode arrive already stable in the clock domain.
 */
`timescale 1ns/1ps
module rhc_xtal_tick (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // configuration
    input  wire logic [7:0] nom_trim,
    input  wire logic [7:0] therm_trim,
    input  wire logic       fast,
    // ticks
    output logic            tick,
    output logic            cfg_tick
);

    logic [31:0] phase_r;
    logic [31:0] inc_r;
    logic [7:0]  cfg_cnt_r;
    logic signed [8:0]  trim_sum;
    logic signed [8:0]  trim_clamp;
    logic [32:0] phase_nxt;

    // sum of both trims, clipped so total correction stays in range
    always_comb begin
        trim_sum   = 9'(signed'(nom_trim)) + 9'(signed'(therm_trim));
        trim_clamp = trim_sum;
        if (trim_sum > 9'(rhc_pkg::TRIM_LIM)) begin
            trim_clamp = 9'(rhc_pkg::TRIM_LIM);
        end else if (trim_sum < -9'(rhc_pkg::TRIM_LIM)) begin
            trim_clamp = -9'(rhc_pkg::TRIM_LIM);
        end
    end

    // step is recomputed only at config ticks so no half-updated value is used
    always_ff @(posedge clk) begin
        if (rst) begin
            inc_r <= 32'(rhc_pkg::PHASE_INC_NOM);
        end else if (cfg_tick) begin
            if (fast) begin
                inc_r <= 32'((rhc_pkg::PHASE_INC_NOM
                        + longint'(trim_clamp) * rhc_pkg::TRIM_STEP)
                        * rhc_pkg::FAST_MULT);
            end else begin
                inc_r <= 32'(rhc_pkg::PHASE_INC_NOM
                        + longint'(trim_clamp) * rhc_pkg::TRIM_STEP);
            end
        end
    end

    assign phase_nxt = {1'b0, phase_r} + {1'b0, inc_r};

    // carry out of the accumulator is the tick; adding steps adds pulses
    always_ff @(posedge clk) begin
        if (rst) begin
            phase_r <= 32'h0000_0000;
            tick    <= 1'b0;
        end else begin
            phase_r <= phase_nxt[31:0];
            tick    <= phase_nxt[32];
        end
    end

    // 128 Hz enable derived from the tick
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_cnt_r <= 8'h00;
            cfg_tick  <= 1'b0;
        end else begin
            cfg_tick <= 1'b0;
            if (tick) begin
                cfg_cnt_r <= cfg_cnt_r + 8'h01;
                cfg_tick  <= (cfg_cnt_r == 8'(rhc_pkg::CFG_DIV - 1));
            end
        end
    end

endmodule

//--- rtl/rhc_cal_out.sv
/*
 * calibration square wave: toggles after a half period of timekeeping
 * ticks chosen by the rate field. assumes the tick already runs fast
 * in the short-window modes.
 */
`timescale 1ns/1ps
module rhc_cal_out (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // control
    input  wire logic       tick,
    input  wire logic       enable,
    input  wire logic [1:0] rate,
    // output
    output logic            cal
);

    logic [14:0] cnt_r;
    logic [14:0] half;

    // half period per rate code
    always_comb begin
        case (rate)
            2'b00:   half = 15'(rhc_pkg::CAL_HALF_00);
            2'b01:   half = 15'(rhc_pkg::CAL_HALF_01);
            2'b10:   half = 15'(rhc_pkg::CAL_HALF_10);
            2'b11:   half = 15'(rhc_pkg::CAL_HALF_11);
            default: half = 15'(rhc_pkg::CAL_HALF_00);
        endcase
    end

    // held low and phase-reset while disabled so each start is clean
    always_ff @(posedge clk) begin
        if (rst || !enable) begin
            cnt_r <= 15'h0000;
            cal   <= 1'b0;
        end else if (tick) begin
            if (cnt_r >= half - 15'h0001) begin
                cnt_r <= 15'h0000;
                cal   <= ~cal;
            end else begin
                cnt_r <= cnt_r + 15'h0001;
            end
        end
    end

endmodule

//--- rtl/rhc_top.sv
/*
 * hours counter, interval alarm, crystal trims and pin-function register
 * of the real-time clock, reached through the processor's special
 * function register port. assumes the minutes counter supplies a carry
 * pulse, the configuration register supplies its bits as levels, and
 * SYS_RST is the power-on reset (warm resets never reach this block).
 */
`timescale 1ns/1ps
module rhc_top (
    // clock and power-on reset
    input  wire logic       CLK,
    input  wire logic       SYS_RST,
    // special function register port
    input  wire logic [7:0] SFR_ADDR,
    input  wire logic       SFR_WR,
    input  wire logic [7:0] SFR_WDATA,
    output logic      [7:0] SFR_RDATA,
    input  wire logic       KEY_UNLOCK,
    // rest of the clock
    input  wire logic       MIN_CARRY,
    input  wire logic       IVL_TICK,
    input  wire logic       CFG_DAY_LEN,
    input  wire logic       CFG_SINGLE_INT,
    input  wire logic       CFG_IVL_EN,
    output logic            XTAL_TICK,
    output logic            CFG_TICK_128,
    // event flags and pending interrupt
    input  wire logic       MIDNIGHT_CLR,
    input  wire logic       ALARM_CLR,
    input  wire logic       IRQ_ACK,
    output logic            MIDNIGHT_FLAG,
    output logic            ALARM_FLAG,
    output logic            RTC_IRQ_PEND,
    // calibration pin and external interrupt pin roles
    output logic            CAL_OUT,
    output logic            CAL_OE,
    output logic            IRQ1_GPIO_SEL,
    output logic            IRQ1_BATT_SEL,
    output logic            IRQ1_IN_EN,
    output logic            IRQ0_IN_EN
);

    logic [7:0] hours_count_r;
    logic [7:0] interval_compare_r;
    logic [7:0] nominal_crystal_trim_r;
    logic [7:0] thermal_crystal_trim_r;
    logic [7:0] pin_function_config_r;
    logic [7:0] cmp_act_r;
    logic [7:0] ivl_cnt_r;
    logic       ivl_hold_r;
    logic       day_len_r;
    logic       single_r;
    logic       ivl_en_r;
    logic [7:0] nom_act_r;
    logic [7:0] therm_act_r;
    logic       fast_act_r;
    logic       day_wrap;
    logic       alarm_hit;
    logic [7:0] hour_last;
    logic [7:0] ivl_cnt_nxt;
    logic       wr_hours;
    logic       wr_cmp;
    logic       wr_nom;
    logic       wr_therm;
    logic       wr_pf;
    logic       tick;
    logic       cfg_tick;
    logic       cal_wave;

    // write decode; hours and pin setup need the unlock key
    assign wr_hours = SFR_WR && (SFR_ADDR == rhc_pkg::OFS_HOURS_COUNT) && KEY_UNLOCK;
    assign wr_cmp   = SFR_WR && (SFR_ADDR == rhc_pkg::OFS_IVL_COMPARE);
    assign wr_nom   = SFR_WR && (SFR_ADDR == rhc_pkg::OFS_NOM_TRIM);
    assign wr_therm = SFR_WR && (SFR_ADDR == rhc_pkg::OFS_THERM_TRIM);
    assign wr_pf    = SFR_WR && (SFR_ADDR == rhc_pkg::OFS_PIN_FUNC) && KEY_UNLOCK;

    // trimmed crystal tick and the 128 Hz resample enable
    rhc_xtal_tick u_rhc_xtal_tick (
        .clk        (CLK),
        .rst        (SYS_RST),
        .nom_trim   (nom_act_r),
        .therm_trim (therm_act_r),
        .fast       (fast_act_r),
        .tick       (tick),
        .cfg_tick   (cfg_tick)
    );

    // calibration square wave generator
    rhc_cal_out u_rhc_cal_out (
        .clk    (CLK),
        .rst    (SYS_RST),
        .tick   (tick),
        .enable (pin_function_config_r[rhc_pkg::PF_CAL_EN]),
        .rate   (pin_function_config_r[rhc_pkg::PF_RATE_HI:rhc_pkg::PF_RATE_LO]),
        .cal    (cal_wave)
    );

    // only power-on clears the trims; warm resets are simply not wired in
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            nominal_crystal_trim_r <= rhc_pkg::REG_RESET;
        end else begin
            if (wr_nom) begin
                nominal_crystal_trim_r <= SFR_WDATA;
            end
        end
    end

    // thermal trim, rewritten by software after each temperature reading
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            thermal_crystal_trim_r <= rhc_pkg::REG_RESET;
        end else begin
            if (wr_therm) begin
                thermal_crystal_trim_r <= SFR_WDATA;
            end
        end
    end

    // compare value as written by software, used only after resampling
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            interval_compare_r <= rhc_pkg::REG_RESET;
        end else begin
            if (wr_cmp) begin
                interval_compare_r <= SFR_WDATA;
            end
        end
    end

    // pin-function register; bit 4 is stored as written, software is
    // expected to keep it zero, so no logic is spent on masking it
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            pin_function_config_r <= rhc_pkg::REG_RESET;
        end else begin
            if (wr_pf) begin
                pin_function_config_r <= SFR_WDATA;
            end
        end
    end

    // resample the interval side at the 128 Hz enable: a write lands
    // within one period, and counters never see a value change mid-tick
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            cmp_act_r <= rhc_pkg::REG_RESET;
            day_len_r <= 1'b0;
            single_r  <= 1'b0;
            ivl_en_r  <= 1'b0;
        end else if (cfg_tick) begin
            cmp_act_r <= interval_compare_r;
            day_len_r <= CFG_DAY_LEN;
            single_r  <= CFG_SINGLE_INT;
            ivl_en_r  <= CFG_IVL_EN;
        end
    end

    // trims reach the tick only here, so the phase step never changes
    // in the middle of a crystal period
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            nom_act_r   <= rhc_pkg::REG_RESET;
            therm_act_r <= rhc_pkg::REG_RESET;
        end else if (cfg_tick) begin
            nom_act_r   <= nominal_crystal_trim_r;
            therm_act_r <= thermal_crystal_trim_r;
        end
    end

    // short-window speed-up follows rate bit 1 at the same safe point
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            fast_act_r <= 1'b0;
        end else if (cfg_tick) begin
            fast_act_r <= pin_function_config_r[rhc_pkg::PF_RATE_HI];
        end
    end

    // hour wrap point follows the day-length select
    assign hour_last = day_len_r ? rhc_pkg::HOUR_LAST_24 : rhc_pkg::HOUR_LAST_256;
    assign day_wrap  = MIN_CARRY && !wr_hours && (hours_count_r >= hour_last);

    // hours counter; a software write wins over a same-cycle carry
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            hours_count_r <= rhc_pkg::REG_RESET;
        end else if (wr_hours) begin
            hours_count_r <= SFR_WDATA;
        end else if (MIN_CARRY) begin
            if (day_wrap) begin
                hours_count_r <= 8'h00;
            end else begin
                hours_count_r <= hours_count_r + 8'h01;
            end
        end
    end

    // interval counter: the match is tested on the incremented count
    assign ivl_cnt_nxt = ivl_cnt_r + 8'h01;
    assign alarm_hit   = ivl_en_r && !ivl_hold_r && IVL_TICK && (ivl_cnt_nxt == cmp_act_r);

    // disabled timer is held clear; one-shot mode parks after the alarm
    always_ff @(posedge CLK) begin
        if (SYS_RST || !ivl_en_r) begin
            ivl_cnt_r  <= 8'h00;
            ivl_hold_r <= 1'b0;
        end else if (alarm_hit) begin
            ivl_cnt_r  <= 8'h00;
            ivl_hold_r <= single_r;
        end else if (IVL_TICK && !ivl_hold_r) begin
            ivl_cnt_r  <= ivl_cnt_nxt;
        end
    end

    // rollover flag; a new event beats a clear in the same cycle
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            MIDNIGHT_FLAG <= 1'b0;
        end else begin
            MIDNIGHT_FLAG <= day_wrap || (MIDNIGHT_FLAG && !MIDNIGHT_CLR);
        end
    end

    // alarm flag, same set-wins rule so no event is lost to a late clear
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            ALARM_FLAG <= 1'b0;
        end else begin
            ALARM_FLAG <= alarm_hit || (ALARM_FLAG && !ALARM_CLR);
        end
    end

    // merged pending request, independent of the flags above
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            RTC_IRQ_PEND <= 1'b0;
        end else begin
            RTC_IRQ_PEND <= day_wrap || alarm_hit || (RTC_IRQ_PEND && !IRQ_ACK);
        end
    end

    // calibration pin, registered so the pin comes straight from a flop
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            CAL_OE  <= 1'b0;
            CAL_OUT <= 1'b0;
        end else begin
            CAL_OE  <= pin_function_config_r[rhc_pkg::PF_CAL_EN];
            CAL_OUT <= cal_wave && pin_function_config_r[rhc_pkg::PF_CAL_EN];
        end
    end

    // external interrupt pin roles, decoded from the stored register
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            IRQ1_GPIO_SEL <= 1'b0;
            IRQ1_BATT_SEL <= 1'b0;
            IRQ1_IN_EN    <= 1'b0;
            IRQ0_IN_EN    <= 1'b0;
        end else begin
            IRQ1_GPIO_SEL <= (pin_function_config_r[2:1] == 2'b00);
            IRQ1_BATT_SEL <= (pin_function_config_r[2:1] == 2'b01);
            IRQ1_IN_EN    <= (pin_function_config_r[3:2] == 2'b11);
            IRQ0_IN_EN    <= pin_function_config_r[rhc_pkg::PF_IRQ0];
        end
    end

    // timekeeping enables shared with the rest of the clock
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            XTAL_TICK    <= 1'b0;
            CFG_TICK_128 <= 1'b0;
        end else begin
            XTAL_TICK    <= tick;
            CFG_TICK_128 <= cfg_tick;
        end
    end

    // read data registered one cycle after the address; unmapped reads zero
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            SFR_RDATA <= 8'h00;
        end else begin
            case (SFR_ADDR)
                rhc_pkg::OFS_HOURS_COUNT: SFR_RDATA <= hours_count_r;
                rhc_pkg::OFS_IVL_COMPARE: SFR_RDATA <= interval_compare_r;
                rhc_pkg::OFS_NOM_TRIM:    SFR_RDATA <= nominal_crystal_trim_r;
                rhc_pkg::OFS_THERM_TRIM:  SFR_RDATA <= thermal_crystal_trim_r;
                rhc_pkg::OFS_PIN_FUNC:    SFR_RDATA <= pin_function_config_r;
                default:                  SFR_RDATA <= 8'h00;
            endcase
        end
    end

endmodule

//--- bench/rhc_top_properties.sv
/*
 * checker for rhc_top: pin-function decodes, pending irq and crystal tick.
 * assumes zero trims and normal speed until trims or pins are written.
 */
`timescale 1ns/1ps
module rhc_top_properties (
    // clock and power-on reset
    input wire logic       CLK,
    input wire logic       SYS_RST,
    // register port
    input wire logic [7:0] SFR_ADDR,
    input wire logic       SFR_WR,
    input wire logic [7:0] SFR_WDATA,
    input wire logic       KEY_UNLOCK,
    // events
    input wire logic       XTAL_TICK,
    input wire logic       MIDNIGHT_CLR,
    input wire logic       IRQ_ACK,
    input wire logic       MIDNIGHT_FLAG,
    input wire logic       ALARM_FLAG,
    input wire logic       RTC_IRQ_PEND,
    // pins
    input wire logic       CAL_OUT,
    input wire logic       CAL_OE,
    input wire logic       IRQ1_GPIO_SEL,
    input wire logic       IRQ1_BATT_SEL,
    input wire logic       IRQ1_IN_EN,
    input wire logic       IRQ0_IN_EN
);
    localparam int GAP_LO = 7628;
    localparam int GAP_HI = 7629;
    logic [15:0] gap_r;
    logic        seen_r;
    logic        dirty_r;
    logic        pf_wr;
    logic        cfg_wr;

    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    // accepted writes; trim or pin writes may retune the tick later
    assign pf_wr  = SFR_WR && KEY_UNLOCK && (SFR_ADDR == rhc_pkg::OFS_PIN_FUNC);
    assign cfg_wr = pf_wr || (SFR_WR && (SFR_ADDR == rhc_pkg::OFS_NOM_TRIM
                    || SFR_ADDR == rhc_pkg::OFS_THERM_TRIM));

    // gap since last tick; spacing only trusted while nothing was retuned
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            gap_r   <= 16'h0000;
            seen_r  <= 1'b0;
            dirty_r <= 1'b0;
        end else begin
            gap_r <= XTAL_TICK ? 16'h0000 : gap_r + 16'h0001;
            if (XTAL_TICK) seen_r <= 1'b1;
            if (cfg_wr) dirty_r <= 1'b1;
        end
    end

    a_cal_oe_follow: assert property (
        pf_wr |-> ##2 (CAL_OE == $past(SFR_WDATA[7], 2)))
        else $error("calibration enable does not follow bit 7");
    a_cal_quiet: assert property (
        !CAL_OE && !$past(CAL_OE) |-> !CAL_OUT)
        else $error("calibration wave driven while disabled");
    a_irq1_role: assert property (
        pf_wr |-> ##2 (IRQ1_GPIO_SEL == ($past(SFR_WDATA[2:1], 2) == 2'b00))
        && (IRQ1_BATT_SEL == ($past(SFR_WDATA[2:1], 2) == 2'b01)))
        else $error("irq1 pin role decode wrong");
    a_irq_inputs: assert property (
        pf_wr |-> ##2 (IRQ1_IN_EN == ($past(SFR_WDATA[3:2], 2) == 2'b11))
        && (IRQ0_IN_EN == $past(SFR_WDATA[0], 2)))
        else $error("irq input enable decode wrong");
    a_irq_hold: assert property (
        RTC_IRQ_PEND && !IRQ_ACK |=> RTC_IRQ_PEND)
        else $error("pending irq dropped without acknowledge");
    a_mid_hold: assert property (
        MIDNIGHT_FLAG && !MIDNIGHT_CLR |=> MIDNIGHT_FLAG)
        else $error("rollover flag dropped without clear");
    a_mid_irq: assert property (
        $rose(MIDNIGHT_FLAG) |-> RTC_IRQ_PEND)
        else $error("rollover without pending irq");
    a_alarm_irq: assert property (
        $rose(ALARM_FLAG) |-> RTC_IRQ_PEND)
        else $error("alarm without pending irq");
    a_tick_space: assert property (
        XTAL_TICK && seen_r && !dirty_r |-> gap_r inside {[GAP_LO:GAP_HI]})
        else $error("crystal tick spacing off");

    c_rollover: cover property ($rose(MIDNIGHT_FLAG));
    c_cal_on: cover property (pf_wr ##2 CAL_OE);
    c_tick: cover property (XTAL_TICK && seen_r && !dirty_r);
endmodule

bind rhc_top rhc_top_properties u_rhc_top_properties (
    .CLK(CLK), .SYS_RST(SYS_RST), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR),
    .SFR_WDATA(SFR_WDATA), .KEY_UNLOCK(KEY_UNLOCK), .XTAL_TICK(XTAL_TICK),
    .MIDNIGHT_CLR(MIDNIGHT_CLR), .IRQ_ACK(IRQ_ACK), .MIDNIGHT_FLAG(MIDNIGHT_FLAG),
    .ALARM_FLAG(ALARM_FLAG), .RTC_IRQ_PEND(RTC_IRQ_PEND), .CAL_OUT(CAL_OUT),
    .CAL_OE(CAL_OE), .IRQ1_GPIO_SEL(IRQ1_GPIO_SEL), .IRQ1_BATT_SEL(IRQ1_BATT_SEL),
    .IRQ1_IN_EN(IRQ1_IN_EN), .IRQ0_IN_EN(IRQ0_IN_EN));

//--- bench/rhc_top_tb.sv
/*
 * self-checking bench for rhc_top: register table, pin decodes, hours.
 * assumes the 128 Hz resample (~2M cycles away) never comes within the run (~47k cycles).
 */
`timescale 1ns/1ps
module rhc_top_tb;
    typedef struct packed { logic [7:0] a; logic [7:0] d; logic k; logic [7:0] e; } rhc_row_t;
    logic       CLK, SYS_RST, SFR_WR, KEY_UNLOCK, MIN_CARRY, IVL_TICK;
    logic       CFG_DAY_LEN, CFG_SINGLE_INT, CFG_IVL_EN, MIDNIGHT_CLR, ALARM_CLR, IRQ_ACK;
    logic [7:0] SFR_ADDR, SFR_WDATA, SFR_RDATA, pf, t0, tick_cnt;
    logic       XTAL_TICK, CFG_TICK_128, MIDNIGHT_FLAG, ALARM_FLAG, RTC_IRQ_PEND;
    logic       CAL_OUT, CAL_OE, IRQ1_GPIO_SEL, IRQ1_BATT_SEL, IRQ1_IN_EN, IRQ0_IN_EN;
    logic [7:0] flags;
    logic       cfg_seen;
    int         fail_count, total_checks, i;
    // write, read back; locked and unmapped writes leave old values
    rhc_row_t rows [12] = '{'{8'ha5, 8'h17, 1'b1, 8'h17}, '{8'ha5, 8'h42, 1'b0, 8'h17},
        '{8'ha6, 8'hff, 1'b0, 8'hff}, '{8'ha6, 8'h00, 1'b0, 8'h00},
        '{8'hf6, 8'h7f, 1'b0, 8'h7f}, '{8'hf6, 8'h80, 1'b0, 8'h80},
        '{8'hf7, 8'h55, 1'b0, 8'h55}, '{8'hf7, 8'haa, 1'b0, 8'haa},
        '{8'hff, 8'hef, 1'b1, 8'hef}, '{8'hff, 8'h00, 1'b0, 8'hef},
        '{8'h10, 8'h3c, 1'b1, 8'h00}, '{8'hff, 8'h00, 1'b1, 8'h00}};

    rhc_top u_rhc_top (.CLK(CLK), .SYS_RST(SYS_RST), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR),
        .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA), .KEY_UNLOCK(KEY_UNLOCK),
        .MIN_CARRY(MIN_CARRY), .IVL_TICK(IVL_TICK), .CFG_DAY_LEN(CFG_DAY_LEN),
        .CFG_SINGLE_INT(CFG_SINGLE_INT), .CFG_IVL_EN(CFG_IVL_EN), .XTAL_TICK(XTAL_TICK),
        .CFG_TICK_128(CFG_TICK_128), .MIDNIGHT_CLR(MIDNIGHT_CLR), .ALARM_CLR(ALARM_CLR),
        .IRQ_ACK(IRQ_ACK), .MIDNIGHT_FLAG(MIDNIGHT_FLAG), .ALARM_FLAG(ALARM_FLAG),
        .RTC_IRQ_PEND(RTC_IRQ_PEND), .CAL_OUT(CAL_OUT), .CAL_OE(CAL_OE),
        .IRQ1_GPIO_SEL(IRQ1_GPIO_SEL), .IRQ1_BATT_SEL(IRQ1_BATT_SEL),
        .IRQ1_IN_EN(IRQ1_IN_EN), .IRQ0_IN_EN(IRQ0_IN_EN));

    assign flags = {5'h00, MIDNIGHT_FLAG, ALARM_FLAG, RTC_IRQ_PEND};

    // clock: 4 ns period
    always #2 CLK = ~CLK;

    // crystal ticks seen since reset
    always @(posedge CLK) begin
        if (SYS_RST) tick_cnt <= 8'h00;
        else if (XTAL_TICK) tick_cnt <= tick_cnt + 8'h01;
    end

    // sticky record of any 128 Hz resample pulse since reset
    always @(posedge CLK) cfg_seen <= !SYS_RST && (cfg_seen || CFG_TICK_128);

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one-cycle write strobe; key dropped with it so it never lingers
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic k);
        @(negedge CLK);
        SFR_ADDR = a;
        SFR_WDATA = d;
        KEY_UNLOCK = k;
        SFR_WR = 1'b1;
        @(negedge CLK);
        SFR_WR = 1'b0;
        KEY_UNLOCK = 1'b0;
    endtask

    // read data is registered, so look one cycle after the address
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        @(negedge CLK);
        SFR_ADDR = a;
        @(negedge CLK);
        chk(SFR_RDATA, e);
    endtask

    task automatic carry();
        @(negedge CLK);
        MIN_CARRY = 1'b1;
        @(negedge CLK);
        MIN_CARRY = 1'b0;
    endtask

    task automatic finish_test();
        if (fail_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // hang guard, above the expected ~47k cycles yet inside the cycle budget
    initial begin
        repeat (60000) @(posedge CLK);
        fail_count++;
        finish_test();
    end

    // main sequence
    initial begin
        {CLK, SFR_WR, KEY_UNLOCK, MIN_CARRY, IVL_TICK, MIDNIGHT_CLR, ALARM_CLR} = 7'h00;
        {CFG_DAY_LEN, CFG_SINGLE_INT, CFG_IVL_EN, IRQ_ACK} = 4'h0;
        {SFR_ADDR, SFR_WDATA, fail_count, total_checks} = '0;
        SYS_RST = 1'b1;
        repeat (8) @(negedge CLK);
        SYS_RST = 1'b0;
        for (i = 0; i < 10; i += 2) rdchk(rows[i].a, 8'h00);
        chk({flags[2:0], CAL_OE, IRQ1_GPIO_SEL, IRQ1_BATT_SEL, IRQ1_IN_EN, IRQ0_IN_EN},
            8'h08);
        // nominal tick rate: four more ticks within 38000 cycles of the first
        for (i = 0; i < 9000 && tick_cnt == 8'h00; i++) @(negedge CLK);
        t0 = tick_cnt;
        repeat (38000) @(negedge CLK);
        chk(tick_cnt - t0, 8'h04);
        // the resample enable needs 256 ticks, so none may have come yet
        chk({7'h00, cfg_seen}, 8'h00);
        for (i = 0; i < 12; i++) begin
            wr(rows[i].a, rows[i].d, rows[i].k);
            rdchk(rows[i].a, rows[i].e);
        end
        // every enable, rate and pin role; bit 4 always written zero;
        // the wave starts low and needs many ticks to toggle, so it reads low
        for (i = 0; i < 128; i++) begin
            pf = {i[6:4], 1'b0, i[3:0]};
            wr(8'hff, pf, 1'b1);
            repeat (3) @(negedge CLK);
            chk({2'b00, CAL_OUT, CAL_OE, IRQ1_GPIO_SEL, IRQ1_BATT_SEL, IRQ1_IN_EN,
                IRQ0_IN_EN}, {3'b000, pf[7], pf[2:1] == 2'b00, pf[2:1] == 2'b01,
                pf[3:2] == 2'b11, pf[0]});
        end
        wr(8'ha5, 8'h05, 1'b1);
        carry();
        rdchk(8'ha5, 8'h06);
        wr(8'ha5, 8'hfe, 1'b1);
        carry();
        rdchk(8'ha5, 8'hff);
        chk(flags, 8'h00);
        carry();
        rdchk(8'ha5, 8'h00);
        chk(flags, 8'h05);
        // interval timer still disabled after reset: ticks give no alarm
        for (i = 0; i < 4; i++) begin
            @(negedge CLK) IVL_TICK = 1'b1;
            @(negedge CLK) IVL_TICK = 1'b0;
        end
        @(negedge CLK) MIDNIGHT_CLR = 1'b1;
        @(negedge CLK) MIDNIGHT_CLR = 1'b0;
        chk(flags, 8'h01);
        @(negedge CLK) IRQ_ACK = 1'b1;
        @(negedge CLK) IRQ_ACK = 1'b0;
        chk(flags, 8'h00);
        // second power-on reset clears trims and hours
        wr(8'ha5, 8'h09, 1'b1);
        SYS_RST = 1'b1;
        repeat (8) @(negedge CLK);
        SYS_RST = 1'b0;
        for (i = 0; i < 10; i += 2) rdchk(rows[i].a, 8'h00);
        finish_test();
    end
endmodule
